// >>> rtl/sbm_pkg.sv
// Constants and types for the sub-CPU buffer memory mapper.
// Assumes one system clock and a synchronous active-high reset.

package sbm_pkg;

  localparam int unsigned BUF_AW = 24;

  // Region boundaries of the external data space
  localparam logic [15:0] W2_BASE   = 16'hd000;
  localparam logic [15:0] SEG_BASE  = 16'he000;
  localparam logic [15:0] REG_BASE  = 16'hff00;
  localparam logic [15:0] DEAD_BASE = 16'hffc0;
  localparam logic [15:0] GCS_LAST  = 16'hffdf;
  localparam logic [15:0] FETCH_TOP = 16'hc000;

  // Register offsets
  localparam logic [15:0] OFF_W1_HI  = 16'hff18;
  localparam logic [15:0] OFF_W1_LO  = 16'hff19;
  localparam logic [15:0] OFF_W2_HI  = 16'hff1a;
  localparam logic [15:0] OFF_W2_LO  = 16'hff1b;
  localparam logic [15:0] OFF_SEG_LO = 16'hff1c;
  localparam logic [15:0] OFF_SEG_HI = 16'hff1d;
  localparam logic [15:0] OFF_CONF   = 16'hff1e;

  // Writable bit masks, reserved bits read zero
  localparam logic [7:0] MASK_W1_LO  = 8'hfc;
  localparam logic [7:0] MASK_W2_LO  = 8'hf4;
  localparam logic [7:0] MASK_SEG_HI = 8'h0f;
  localparam logic [7:0] MASK_CONF   = 8'h03;

  // Configuration fields and reset value
  localparam int unsigned CONF_FAST  = 0;
  localparam int unsigned CONF_DEBUG = 1;
  localparam logic [7:0]  RST_REG    = 8'h00;

  typedef enum {
    RG_W1, RG_W2, RG_SEG, RG_REG, RG_DEAD
  } sbm_region_t;

  typedef enum {
    ST_IDLE, ST_WAIT
  } sbm_state_t;

  typedef struct packed {
    logic              ale_s1, ale_s2, ale_p;
    logic              rd_n_s1, rd_n_s2, rd_n_p;
    logic              wr_n_s1, wr_n_s2, wr_n_p;
    logic              program_store_strobe_n_s1, program_store_strobe_n_s2;
    logic [7:0]        ad_s1, ad_s2;
    logic [7:0]        ahi_s1, ahi_s2;
    logic [15:0]       addr;
    sbm_state_t        st;
    logic              mem_req, mem_we, mem_abort;
    logic [BUF_AW-1:0] mem_addr;
    logic [7:0]        mem_wdata;
    logic [7:0]        rdata;
    logic              ad_oe;
    logic              reg_wr;
    logic [7:0]        reg_addr, reg_wdata;
    logic              cs_n;
    logic [3:0]        gaddr;
    logic [7:0]        w1_hi, w1_lo, w2_hi, w2_lo, seg_lo, seg_hi, conf;
  } sbm_regs_t;

endpackage

// >>> rtl/sbm_mapper.sv
// Sub-CPU bus to buffer memory mapper with its window registers.
// Assumes CPU pins are asynchronous and strobes last several clocks.
`timescale 1ns/1ns

module sbm_mapper (
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_rst,
  input  wire logic                       i_ale,
  input  wire logic                       i_rd_n,
  input  wire logic                       i_wr_n,
  input  wire logic                       i_program_store_strobe_n,
  input  wire logic [7:0]                 i_ad,
  input  wire logic [7:0]                 i_addr_hi,
  input  wire logic                       i_generic_mode,
  input  wire logic                       i_mem_done,
  input  wire logic [7:0]                 i_mem_rdata,
  input  wire logic [7:0]                 i_reg_rdata,
  output logic      [7:0]                 o_ad,
  output logic                            o_ad_oe,
  output logic                            o_mem_req,
  output logic                            o_mem_we,
  output logic                            o_mem_abort,
  output logic      [sbm_pkg::BUF_AW-1:0] o_mem_addr,
  output logic      [7:0]                 o_mem_wdata,
  output logic                            o_reg_wr,
  output logic      [7:0]                 o_reg_addr,
  output logic      [7:0]                 o_reg_wdata,
  output logic                            o_generic_cs_n,
  output logic      [3:0]                 o_generic_addr
);

  ////////////////////////////////////////////////////////////////////////////

  function automatic sbm_pkg::sbm_region_t region_of(input logic [15:0] a);
    if (a >= sbm_pkg::DEAD_BASE) begin
      region_of = sbm_pkg::RG_DEAD;
    end else if (a >= sbm_pkg::REG_BASE) begin
      region_of = sbm_pkg::RG_REG;
    end else if (a >= sbm_pkg::SEG_BASE) begin
      region_of = sbm_pkg::RG_SEG;
    end else if (a >= sbm_pkg::W2_BASE) begin
      region_of = sbm_pkg::RG_W2;
    end else begin
      region_of = sbm_pkg::RG_W1;
    end
  endfunction

  // Segment base times 2560 as two shifts, no multiplier
  function automatic logic [sbm_pkg::BUF_AW-1:0] seg_scale(input logic [11:0] s);
    seg_scale = {1'b0, s, 11'h000} + {3'b000, s, 9'h000};
  endfunction

  function automatic logic [sbm_pkg::BUF_AW-1:0] buf_addr(
    input logic [15:0] a,
    input sbm_pkg::sbm_regs_t q
  );
    logic [13:0] b1;
    logic [13:0] b2;
    b1 = {q.w1_hi, q.w1_lo[7:2]};
    b2 = {q.w2_hi, q.w2_lo[7:2]};
    case (region_of(a))
      sbm_pkg::RG_W1:  buf_addr = {b1 + {8'h00, a[15:10]}, a[9:0]};
      sbm_pkg::RG_W2:  buf_addr = {b2 + {12'h000, a[11:10]}, a[9:0]};
      // No limit check; window may run past the buffer
      sbm_pkg::RG_SEG: buf_addr = seg_scale({q.seg_hi[3:0], q.seg_lo})
                                  + {11'h000, a[12:0]};
      default:         buf_addr = {16'h0000, a[7:0]};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  sbm_pkg::sbm_regs_t r_reg;
  sbm_pkg::sbm_regs_t r_next;

  logic                ale_fall;
  logic                rd_fall;
  logic                wr_fall;
  logic                rd_rise;
  logic [15:0]         a_new;
  sbm_pkg::sbm_region_t rg_new;
  sbm_pkg::sbm_region_t rg_cur;
  logic                fast;
  logic                ram_new;
  logic                ram_cur;
  logic                external_data_space;

  assign ale_fall = r_reg.ale_p & ~r_reg.ale_s2;
  assign rd_fall  = r_reg.rd_n_p & ~r_reg.rd_n_s2;
  assign rd_rise  = ~r_reg.rd_n_p & r_reg.rd_n_s2;
  assign wr_fall  = r_reg.wr_n_p & ~r_reg.wr_n_s2;
  assign a_new    = {r_reg.ahi_s2, r_reg.ad_s2};
  assign rg_new   = region_of(a_new);
  assign rg_cur   = region_of(r_reg.addr);
  assign fast     = r_reg.conf[sbm_pkg::CONF_FAST];
  assign ram_new  = (rg_new == sbm_pkg::RG_W1) || (rg_new == sbm_pkg::RG_W2) ||
                    (rg_new == sbm_pkg::RG_SEG);
  assign ram_cur  = (rg_cur == sbm_pkg::RG_W1) || (rg_cur == sbm_pkg::RG_W2) ||
                    (rg_cur == sbm_pkg::RG_SEG);
  // Only a data strobe with program strobe high is a data access
  assign external_data_space    = r_reg.program_store_strobe_n_s2;

  always_comb begin
    r_next           = r_reg;
    r_next.mem_req   = 1'b0;
    r_next.mem_abort = 1'b0;
    r_next.reg_wr    = 1'b0;
    // Pin synchronisers
    r_next.ale_s1    = i_ale;
    r_next.ale_s2    = r_reg.ale_s1;
    r_next.ale_p     = r_reg.ale_s2;
    r_next.rd_n_s1   = i_rd_n;
    r_next.rd_n_s2   = r_reg.rd_n_s1;
    r_next.rd_n_p    = r_reg.rd_n_s2;
    r_next.wr_n_s1   = i_wr_n;
    r_next.wr_n_s2   = r_reg.wr_n_s1;
    r_next.wr_n_p    = r_reg.wr_n_s2;
    r_next.program_store_strobe_n_s1 = i_program_store_strobe_n;
    r_next.program_store_strobe_n_s2 = r_reg.program_store_strobe_n_s1;
    r_next.ad_s1     = i_ad;
    r_next.ad_s2     = r_reg.ad_s1;
    r_next.ahi_s1    = i_addr_hi;
    r_next.ahi_s2    = r_reg.ahi_s1;

    if (i_mem_done && r_reg.st == sbm_pkg::ST_WAIT) begin
      r_next.st = sbm_pkg::ST_IDLE;
      if (!r_reg.mem_we) begin
        r_next.rdata = i_mem_rdata;
      end
    end

    if (ale_fall) begin
      // Address held for the whole access
      r_next.addr   = a_new;
      r_next.gaddr  = a_new[3:0];
      // Outside registers decode reads from this byte
      r_next.reg_addr = a_new[7:0];
      r_next.cs_n   = ~(i_generic_mode && a_new >= sbm_pkg::DEAD_BASE &&
                        a_new <= sbm_pkg::GCS_LAST);
      if (fast && ram_new && a_new >= sbm_pkg::FETCH_TOP) begin
        // Costs bandwidth: starts even if no data strobe follows
        r_next.mem_req   = 1'b1;
        r_next.mem_abort = 1'b1;
        r_next.mem_we    = 1'b0;
        r_next.mem_addr  = buf_addr(a_new, r_reg);
        r_next.st        = sbm_pkg::ST_WAIT;
      end
    end else if (rd_fall && external_data_space) begin
      if (rg_cur == sbm_pkg::RG_REG) begin
        r_next.ad_oe = 1'b1;
        case (r_reg.addr)
          sbm_pkg::OFF_W1_HI:  r_next.rdata = r_reg.w1_hi;
          sbm_pkg::OFF_W1_LO:  r_next.rdata = r_reg.w1_lo;
          sbm_pkg::OFF_W2_HI:  r_next.rdata = r_reg.w2_hi;
          sbm_pkg::OFF_W2_LO:  r_next.rdata = r_reg.w2_lo;
          sbm_pkg::OFF_SEG_LO: r_next.rdata = r_reg.seg_lo;
          sbm_pkg::OFF_SEG_HI: r_next.rdata = r_reg.seg_hi;
          sbm_pkg::OFF_CONF:   r_next.rdata = r_reg.conf;
          default:             r_next.rdata = i_reg_rdata;
        endcase
      end else if (ram_cur && !(fast && r_reg.addr < sbm_pkg::FETCH_TOP)) begin
        r_next.ad_oe = 1'b1;
        if (!fast) begin
          r_next.mem_req  = 1'b1;
          r_next.mem_we   = 1'b0;
          r_next.mem_addr = buf_addr(r_reg.addr, r_reg);
          r_next.st       = sbm_pkg::ST_WAIT;
        end
      end else begin
        r_next.ad_oe = 1'b0;
      end
    end else if (wr_fall && external_data_space) begin
      if (rg_cur == sbm_pkg::RG_REG) begin
        r_next.reg_wr    = 1'b1;
        r_next.reg_addr  = r_reg.addr[7:0];
        r_next.reg_wdata = r_reg.ad_s2;
        case (r_reg.addr)
          sbm_pkg::OFF_W1_HI:  r_next.w1_hi  = r_reg.ad_s2;
          sbm_pkg::OFF_W1_LO:  r_next.w1_lo  = r_reg.ad_s2 & sbm_pkg::MASK_W1_LO;
          sbm_pkg::OFF_W2_HI:  r_next.w2_hi  = r_reg.ad_s2;
          sbm_pkg::OFF_W2_LO:  r_next.w2_lo  = r_reg.ad_s2 & sbm_pkg::MASK_W2_LO;
          sbm_pkg::OFF_SEG_LO: r_next.seg_lo = r_reg.ad_s2;
          sbm_pkg::OFF_SEG_HI: r_next.seg_hi = r_reg.ad_s2 & sbm_pkg::MASK_SEG_HI;
          sbm_pkg::OFF_CONF:   r_next.conf   = r_reg.ad_s2 & sbm_pkg::MASK_CONF;
          default:             r_next.conf   = r_reg.conf;
        endcase
        if (r_reg.conf[sbm_pkg::CONF_DEBUG]) begin
          r_next.mem_req   = 1'b1;
          r_next.mem_we    = 1'b1;
          r_next.mem_addr  = buf_addr(r_reg.addr, r_reg);
          r_next.mem_wdata = r_reg.ad_s2;
          r_next.st        = sbm_pkg::ST_WAIT;
        end
      end else if (ram_cur && !(fast && r_reg.addr < sbm_pkg::FETCH_TOP)) begin
        r_next.mem_req   = 1'b1;
        r_next.mem_we    = 1'b1;
        r_next.mem_addr  = buf_addr(r_reg.addr, r_reg);
        r_next.mem_wdata = r_reg.ad_s2;
        r_next.st        = sbm_pkg::ST_WAIT;
      end
    end else if (rd_rise) begin
      r_next.ad_oe = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      r_reg        <= '0;
      r_reg.ale_p  <= 1'b0;
      r_reg.rd_n_s1 <= 1'b1;
      r_reg.rd_n_s2 <= 1'b1;
      r_reg.rd_n_p <= 1'b1;
      r_reg.wr_n_s1 <= 1'b1;
      r_reg.wr_n_s2 <= 1'b1;
      r_reg.wr_n_p <= 1'b1;
      r_reg.st     <= sbm_pkg::ST_IDLE;
      r_reg.cs_n   <= 1'b1;
      r_reg.conf   <= sbm_pkg::RST_REG;
      r_reg.w1_hi  <= sbm_pkg::RST_REG;
      r_reg.w1_lo  <= sbm_pkg::RST_REG;
      r_reg.w2_hi  <= sbm_pkg::RST_REG;
      r_reg.w2_lo  <= sbm_pkg::RST_REG;
      r_reg.seg_lo <= sbm_pkg::RST_REG;
      r_reg.seg_hi <= sbm_pkg::RST_REG;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_ad           = r_reg.rdata;
  assign o_ad_oe        = r_reg.ad_oe;
  assign o_mem_req      = r_reg.mem_req;
  assign o_mem_we       = r_reg.mem_we;
  assign o_mem_abort    = r_reg.mem_abort;
  assign o_mem_addr     = r_reg.mem_addr;
  assign o_mem_wdata    = r_reg.mem_wdata;
  assign o_reg_wr       = r_reg.reg_wr;
  assign o_reg_addr     = r_reg.reg_addr;
  assign o_reg_wdata    = r_reg.reg_wdata;
  assign o_generic_cs_n = r_reg.cs_n;
  assign o_generic_addr = r_reg.gaddr;

  ////////////////////////////////////////////////////////////////////////////

  no_low_fetch_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (r_reg.mem_req && $past(fast)) |-> (r_reg.addr >= sbm_pkg::FETCH_TOP))
    else $error("fast mode cycle below fetch top");

  fast_start_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (ale_fall && fast && ram_new && a_new >= sbm_pkg::FETCH_TOP)
    |=> (r_reg.mem_req && !r_reg.mem_we && r_reg.addr == $past(a_new)))
    else $error("fast cycle not started at latch fall");

  abort_read_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    r_reg.mem_abort |-> (r_reg.mem_req && !r_reg.mem_we && $past(ale_fall)))
    else $error("abort outside a fast start");

  slow_start_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (rd_fall && !ale_fall && !fast && external_data_space && ram_cur)
    |=> (r_reg.mem_req && !r_reg.mem_we && !r_reg.mem_abort))
    else $error("slow read cycle not started");

  program_store_strobe_block_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ((rd_fall || wr_fall) && !ale_fall && !external_data_space) |=> !r_reg.mem_req)
    else $error("cycle started during a fetch");

  reg_read_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (rd_fall && !ale_fall && external_data_space && rg_cur == sbm_pkg::RG_REG)
    |=> (r_reg.ad_oe && !r_reg.mem_req))
    else $error("register read went to memory");

  dead_space_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (rd_fall && !ale_fall && external_data_space && rg_cur == sbm_pkg::RG_DEAD)
    |=> (!r_reg.ad_oe && !r_reg.mem_req))
    else $error("dead space access drove bus or memory");

  generic_cs_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (ale_fall && i_generic_mode && a_new >= sbm_pkg::DEAD_BASE &&
     a_new <= sbm_pkg::GCS_LAST) |=> (!r_reg.cs_n && r_reg.gaddr == $past(a_new[3:0])))
    else $error("generic chip select not asserted");

  seg_addr_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (r_reg.mem_req && rg_cur == sbm_pkg::RG_SEG) |->
    (r_reg.mem_addr == ({12'h000, r_reg.seg_hi[3:0], r_reg.seg_lo} * 24'd2560
                        + {11'h000, r_reg.addr[12:0]})))
    else $error("segment address wrong");

  reset_val_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $past(i_rst) |-> (r_reg.conf == 8'h00 && r_reg.w1_hi == 8'h00 && o_generic_cs_n))
    else $error("reset values wrong");

  reg_addr_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ale_fall |=> (r_reg.reg_addr == $past(a_new[7:0])))
    else $error("register address not latched");

  slow_write_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (wr_fall && !ale_fall && !fast && external_data_space && ram_cur)
    |=> (r_reg.mem_req && r_reg.mem_we && r_reg.mem_wdata == $past(r_reg.ad_s2)))
    else $error("slow write cycle wrong");

  dead_write_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (wr_fall && !ale_fall && rg_cur == sbm_pkg::RG_DEAD)
    |=> (!r_reg.mem_req && !r_reg.reg_wr))
    else $error("dead space write reached memory");

  window_two_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (r_reg.mem_req && rg_cur == sbm_pkg::RG_W2) |->
    (r_reg.mem_addr[9:0] == r_reg.addr[9:0] &&
     r_reg.mem_addr[23:10] == {r_reg.w2_hi, r_reg.w2_lo[7:2]} + {12'h000, r_reg.addr[11:10]}))
    else $error("window two address wrong");

endmodule // sbm_mapper

// >>> test/sbm_cpu_model.sv
// Behavioural sub-CPU on the multiplexed address/data bus.
// Assumes the bench starts every access through bus_cycle.
`timescale 1ns/1ns

module sbm_cpu_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_dev_ad,
  input  wire logic       i_dev_oe,
  output logic      [7:0] o_ad,
  output logic            o_ale,
  output logic            o_rd_n,
  output logic            o_wr_n,
  output logic            o_program_store_strobe_n,
  output logic      [7:0] o_addr_hi
);
  logic       drv;
  logic [7:0] val;

  // Released bus shows the inverse, so a stale copy never passes
  assign o_ad = i_rst ? 8'h00 : i_dev_oe ? i_dev_ad : drv ? val : ~val;

  initial begin
    {drv, val, o_ale, o_addr_hi} = '0;
    {o_rd_n, o_wr_n, o_program_store_strobe_n} = 3'b111;
  end

  ////////////////////////////////////////////////////////////
  // Strobes held long past the device synchronisers
  task automatic bus_cycle(input logic [15:0] a, input logic wr, input logic [7:0] wd,
                           input logic fetch, output logic [7:0] rd, output logic oe);
    @(negedge i_clk);
    {o_addr_hi, val, drv, o_ale} = {a, 2'b11};
    repeat (4) @(negedge i_clk);
    o_ale = 1'b0;
    repeat (5) @(negedge i_clk);
    drv = wr;
    if (wr) val = wd;
    o_program_store_strobe_n = ~fetch;
    if (wr) o_wr_n = 1'b0;
    else o_rd_n = 1'b0;
    repeat (12) @(negedge i_clk);
    {rd, oe} = {i_dev_ad, i_dev_oe};
    {o_rd_n, o_wr_n} = 2'b11;
    repeat (6) @(negedge i_clk);
    {drv, o_program_store_strobe_n} = 2'b01;
  endtask
endmodule // sbm_cpu_model

// >>> test/subcpu_buffer_memory_mapper_test.sv
// Self-checking bench for the buffer memory mapper.
// Assumes the CPU model is compiled before it.
`timescale 1ns/1ns

module subcpu_buffer_memory_mapper_test;
  logic        clk, rst, ale, rd_n, wr_n, program_store_strobe_n, gmode, done, ad_oe, req, we, abort;
  logic        reg_wr, cs_n;
  logic [7:0]  ad, dev_ad, ahi, mrd, rrd, mwd, reg_addr, reg_wdata;
  logic [3:0]  gaddr;
  logic [23:0] maddr;
  logic [33:0] cap;
  logic [15:0] rcap;
  int          errors, compares, n_req, n_rw, dly, seed, r;
  int          rm[7];
  int          msk[7] = '{'hff, 'hfc, 'hff, 'hf4, 'hff, 'h0f, 'h03};

  sbm_mapper sbm_mapper_i (
    .i_clk_sys(clk), .i_rst(rst), .i_ale(ale), .i_rd_n(rd_n), .i_wr_n(wr_n),
    .i_program_store_strobe_n(program_store_strobe_n), .i_ad(ad), .i_addr_hi(ahi), .i_generic_mode(gmode),
    .i_mem_done(done), .i_mem_rdata(mrd), .i_reg_rdata(rrd), .o_ad(dev_ad),
    .o_ad_oe(ad_oe), .o_mem_req(req), .o_mem_we(we), .o_mem_abort(abort),
    .o_mem_addr(maddr), .o_mem_wdata(mwd), .o_reg_wr(reg_wr), .o_reg_addr(reg_addr),
    .o_reg_wdata(reg_wdata), .o_generic_cs_n(cs_n), .o_generic_addr(gaddr));

  sbm_cpu_model sbm_cpu_model_i (
    .i_clk(clk), .i_rst(rst), .i_dev_ad(dev_ad), .i_dev_oe(ad_oe), .o_ad(ad),
    .o_ale(ale), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_program_store_strobe_n(program_store_strobe_n), .o_addr_hi(ahi));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////
  // Monitor and a buffer memory that answers three cycles late
  always @(posedge clk) begin
    if (req === 1'b1) begin
      n_req <= n_req + 1;
      cap <= {abort, we, maddr, we ? mwd : 8'h00};
    end
    if (reg_wr === 1'b1) begin
      n_rw <= n_rw + 1;
      rcap <= {reg_addr, reg_wdata};
    end
  end

  always @(negedge clk) begin
    done <= (dly == 1);
    dly <= (req === 1'b1) ? 3 : (dly > 0 ? dly - 1 : 0);
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic int map(input int a);
    int w1, w2, sg;
    w1 = rm[0] * 256 + (rm[1] & 'hfc);
    w2 = rm[2] * 256 + (rm[3] & 'hf4);
    sg = (rm[5] & 'h0f) * 256 + rm[4];
    if (a < 'hd000) return ((w1 / 4 + a / 1024) * 1024 + a % 1024) % 'h1000000;
    if (a < 'he000) return ((w2 / 4 + a / 1024 % 4) * 1024 + a % 1024) % 'h1000000;
    if (a < 'hff00) return (sg * 2560 + a % 'h2000) % 'h1000000;
    return a % 256;
  endfunction

  task automatic chk_dat(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected data at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_req(input logic [37:0] got, input logic [37:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected request at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // One access, predicted from the mirror before it is made
  task automatic acc(input int a, input logic wr, input logic fetch, input int v = -1);
    logic [7:0] wd, rd;
    logic       oe, e, fast, reg_sp;
    int         n0, w0, o;
    wd = v < 0 ? rnd() : v[7:0];
    mrd = rnd();
    rrd = rnd();
    {n0, w0, o} = {n_req, n_rw, a - 'hff18};
    fast = rm[6][0];
    reg_sp = a >= 'hff00 && a < 'hffc0 && !fetch;
    e = a < 'hffc0 && !fetch && (a >= 'hff00 ? wr && rm[6][1] : !(fast && a < 'hc000));
    sbm_cpu_model_i.bus_cycle(a[15:0], wr, wd, fetch, rd, oe);
    chk_req({4'(n_req - n0), e ? cap : 34'h0},
            {4'(e), e ? {fast, wr, 24'(map(a)), wr ? wd : 8'h00} : 34'h0});
    if (!wr) begin
      chk_dat({7'h0, oe}, {7'h0, reg_sp | e});
      if (reg_sp) chk_dat(rd, (o >= 0 && o < 7) ? 8'(rm[o] & msk[o]) : rrd);
      else if (e) chk_dat(rd, mrd);
    end else if (reg_sp) begin
      chk_req({4'(n_rw - w0), 18'h0, rcap}, {4'h1, 18'h0, a[7:0], wd});
      if (o >= 0 && o < 7) rm[o] = wd;
    end
  endtask

  initial begin
    {gmode, mrd, rrd, done, cap, rcap} = '0;
    {errors, compares, n_req, n_rw, dly, seed} = {32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'd70};
    rm = '{default: 0};
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 7; i++) acc('hff18 + i, 0, 0);
    for (int i = 0; i < 6; i++) acc('hff18 + i, 1, 0);
    for (int i = 0; i < 7; i++) acc('hff18 + i, 0, 0);
    foreach (msk[i]) acc('h0000 + i * 'h2000 % 'hff00, i % 2 == 1, 0);
    for (int i = 0; i < 30; i++) begin
      r = {rnd(), rnd()};
      r = i % 3 == 0 ? r % 'hd000 : i % 3 == 1 ? 'hd000 + r % 'h1000 : 'he000 + r % 'h1f00;
      acc(r, rnd() % 2 == 1, 0);
    end
    acc('hcfff, 0, 0);
    acc('hdfff, 1, 0);
    acc('hff1d, 1, 0, 'h0f);
    acc('hff1c, 1, 0, 'hff);
    acc('hfeff, 0, 0);
    acc('h1234, 0, 1);
    acc('hd010, 1, 1);
    foreach (msk[i]) begin
      gmode = i[0];
      acc('hffc0 + i * 9, i[1], 0);
      chk_dat({3'h0, cs_n, gaddr}, {3'h0, !(i[0] && i < 4), 4'(i * 9)});
    end
    acc('hff1e, 1, 0, 'h02);
    acc('hff40, 1, 0);
    acc('hff40, 0, 0);
    acc('hff1e, 1, 0, 'h01);
    acc('h0100, 0, 0);
    acc('hbfff, 0, 0);
    acc('hc000, 0, 0);
    acc('hd800, 0, 0);
    acc('hff1e, 1, 0, 'h00);
    acc('h0100, 0, 0);
    // Second reset after the bases were programmed
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    rm = '{default: 0};
    repeat (3) @(negedge clk);
    for (int i = 0; i < 7; i++) acc('hff18 + i, 0, 0);
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict();
  end
endmodule // subcpu_buffer_memory_mapper_test
